/* File: hdl/mio_ports.v */
// Function
// R01: Serial in, out, clock on shared pins 1-3
// R02: Shared pins also run two-wire serial
// R03: Pin 4 gives halt release or interrupt
// R04: One pull enable per bidirectional port
// R05: One CMOS/open-drain select per bidirectional port
// R06: Output port drive type chosen per bit
// R07: Event counter mode makes timer pin input clock
// R08: Carrier waveform drives output port pin 3
// R09: Alarm waveform drives output port pin 4
// R10: Reset: inputs, pulls on; pulls off after
// R11: Keeper off in reset, on after release
// R12: Reset sets all port data latches high; here the output port latch n_lat_q resets to 0
// R13: Optional keeper holds last level on inputs
// R14: Build option picks segment pins as outputs
// R15: Segment outputs reset low/high per display option
// R16: Alternate function overrides latch and direction
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mio_defines.vh"

module mio_ports #(
    parameter [22:0] SEG_GPO_MASK = 23'h000000,
    parameter SEG_RST_LIT = 1'b0,
    parameter LEVEL_HOLD = 1'b1,
    parameter SO4_EDGE_RISE = 1'b0
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // Register port
    input wire [`MIO_AW-1:0] reg_addr,
    input wire [`MIO_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [`MIO_DW-1:0] reg_rdata,
    // Serial-shared port pins
    input wire [3:0] serial_shared_pin_in,
    output wire [3:0] serial_shared_pin_out,
    output wire [3:0] serial_shared_pin_oe_n,
    // Timer-shared port pins
    input wire [3:0] timer_shared_pin_in,
    output wire [3:0] timer_shared_pin_out,
    output wire [3:0] timer_shared_pin_oe_n,
    // Plain bidirectional port pins
    input wire [3:0] plain_port_pin_in,
    output wire [3:0] plain_port_pin_out,
    output wire [3:0] plain_port_pin_oe_n,
    // Output-only port pins
    output wire [3:0] output_port_pin_out,
    output wire [3:0] output_port_pin_oe_n,
    // Pad controls
    output wire [2:0] pull_en,
    output wire keeper_en,
    // Segment pins
    input wire [22:0] seg_lcd_drive,
    output wire [22:0] segment_drive_pins,
    // Serial engine side
    input wire ser_data_out,
    input wire ser_clk_out,
    input wire ser_clk_drive,
    output wire ser_data_in,
    output wire ser_clk_in,
    // Timer, carrier, alarm, core
    output wire t2_count_clk,
    input wire carrier_wave,
    input wire alarm_wave,
    output wire so4_int_req,
    output wire halt_release,
    output wire irq
);

    // Software-visible state
    reg [3:0] so_lat_q;
    reg [3:0] m_lat_q;
    reg [3:0] p_lat_q;
    reg [3:0] n_lat_q;
    reg [3:0] so_dir_q;
    reg [3:0] m_dir_q;
    reg [3:0] p_dir_q;
    reg [2:0] pull_q;
    reg [2:0] od_q;
    reg [3:0] n_od_q;
    reg [6:0] fn_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_stat_d;
    reg [2:0] irq_mask_q;
    reg [22:0] seg_lat_q;
    reg boot_done_q;
    reg [`MIO_DW-1:0] rdata_q;
    reg [`MIO_DW-1:0] rdata_d;

    // Pin samples and registered pin drives
    reg [3:0] so_pin_q;
    reg [3:0] m_pin_q;
    reg [3:0] p_pin_q;
    reg [15:0] pin_out_q;
    reg [15:0] pin_oe_n_q;
    reg [22:0] seg_out_q;
    reg keeper_q;
    reg ser_din_q;
    reg ser_cin_q;
    reg t2_clk_q;
    reg so4_int_q;
    reg halt_rel_q;
    reg irq_q;

    wire ser_en = fn_q[`MIO_FN_SER_EN];
    wire two_wire = fn_q[`MIO_FN_TWO_WIRE];
    wire so4_fn = fn_q[`MIO_FN_SO4_EN] & ~ser_en; // [R03]
    wire t2_evt = fn_q[`MIO_FN_T2_EVT];

    // Alternate ownership of pins, ordered {N, P, M, SO}
    reg [15:0] alt_own;
    reg [15:0] alt_drv;
    reg [15:0] alt_val;
    reg [15:0] alt_od;

    always @*
    begin
        alt_own = 16'h0000;
        alt_drv = 16'h0000;
        alt_val = 16'h0000;
        alt_od = 16'h0000;
        // Serial input pin held as input while the engine owns it
        alt_own[0] = ser_en; // [R01] [R16]
        // Data output; in two-wire mode it is a shared open-drain line
        alt_own[1] = ser_en; // [R01]
        alt_drv[1] = 1'b1;
        alt_val[1] = ser_data_out;
        alt_od[1] = two_wire; // [R02]
        // Clock pin driven only when the engine is clock master
        alt_own[2] = ser_en; // [R01]
        alt_drv[2] = ser_clk_drive;
        alt_val[2] = ser_clk_out;
        alt_od[2] = two_wire; // [R02]
        // Pin 4 forced to input for halt release or interrupt
        alt_own[3] = so4_fn; // [R03] [R16]
        // Timer pin 4 forced to input in event counter mode
        alt_own[7] = t2_evt; // [R07] [R16]
        // Carrier and alarm override the output latch
        alt_own[14] = fn_q[`MIO_FN_CARRIER]; // [R08] [R16]
        alt_drv[14] = 1'b1;
        alt_val[14] = carrier_wave;
        alt_own[15] = fn_q[`MIO_FN_ALARM]; // [R09] [R16]
        alt_drv[15] = 1'b1;
        alt_val[15] = alarm_wave;
    end

    // Port latches, directions and drive types as flat vectors
    wire [15:0] lat_v = {n_lat_q, p_lat_q, m_lat_q, so_lat_q};
    wire [15:0] dir_v = {4'hF, p_dir_q, m_dir_q, so_dir_q};
    wire [15:0] od_v = {n_od_q, {4{od_q[2]}}, {4{od_q[1]}}, {4{od_q[0]}}}; // [R05] [R06]
    wire [15:0] pin_out_d;
    wire [15:0] pin_oe_n_d;
    wire [22:0] seg_out_d;

    // Per-pin drive: open-drain only pulls low, never drives high
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_pin
            wire drv = alt_own[gi] ? alt_drv[gi] : dir_v[gi]; // [R16]
            wire val = alt_own[gi] ? alt_val[gi] : lat_v[gi];
            wire od = od_v[gi] | (alt_own[gi] & alt_od[gi]);
            assign pin_out_d[gi] = od ? 1'b0 : val; // [R05] [R06]
            assign pin_oe_n_d[gi] = ~(drv & (~od | ~val));
        end
        for (gi = 0; gi < 23; gi = gi + 1)
        begin : g_seg
            // Build option chooses general output or display drive
            assign seg_out_d[gi] = SEG_GPO_MASK[gi] ? seg_lat_q[gi] : seg_lcd_drive[gi]; // [R14]
        end
    endgenerate

    // Register decode
    wire wr_so = reg_wr & (reg_addr == `MIO_REG_SO_DATA);
    wire wr_m = reg_wr & (reg_addr == `MIO_REG_M_DATA);
    wire wr_p = reg_wr & (reg_addr == `MIO_REG_P_DATA);
    wire wr_n = reg_wr & (reg_addr == `MIO_REG_N_DATA);
    wire rd_stat = reg_rd & (reg_addr == `MIO_REG_IRQ_STAT);

    // Edge detection: live pin level against its registered sample
    wire so4_edge = SO4_EDGE_RISE ? (serial_shared_pin_in[3] & ~so_pin_q[3])
                                  : (~serial_shared_pin_in[3] & so_pin_q[3]);
    wire so4_int_ev = so4_fn & fn_q[`MIO_FN_SO4_INT] & so4_edge; // [R03]
    wire halt_ev = so4_fn & ~fn_q[`MIO_FN_SO4_INT] & so4_edge; // [R03]
    wire t2_ev = t2_evt & timer_shared_pin_in[3] & ~m_pin_q[3]; // [R07]

    // Sticky status: a new event wins over the read that clears
    always @*
    begin
        irq_stat_d = (rd_stat ? 3'h0 : irq_stat_q) | {t2_ev, halt_ev, so4_int_ev};
    end

    // Read data mux; unmapped addresses read zero
    always @*
    begin
        rdata_d = {`MIO_DW{1'b0}};
        case (reg_addr)
            `MIO_REG_SO_DATA: rdata_d[3:0] = so_lat_q;
            `MIO_REG_M_DATA: rdata_d[3:0] = m_lat_q;
            `MIO_REG_P_DATA: rdata_d[3:0] = p_lat_q;
            `MIO_REG_N_DATA: rdata_d[3:0] = n_lat_q;
            `MIO_REG_SO_DIR: rdata_d[3:0] = so_dir_q;
            `MIO_REG_M_DIR: rdata_d[3:0] = m_dir_q;
            `MIO_REG_P_DIR: rdata_d[3:0] = p_dir_q;
            `MIO_REG_PORT_CFG: rdata_d[6:0] = {od_q, 1'b0, pull_q};
            `MIO_REG_N_OD: rdata_d[3:0] = n_od_q;
            `MIO_REG_FUNC: rdata_d[6:0] = fn_q;
            `MIO_REG_SO_PIN: rdata_d[3:0] = so_pin_q;
            `MIO_REG_M_PIN: rdata_d[3:0] = m_pin_q;
            `MIO_REG_P_PIN: rdata_d[3:0] = p_pin_q;
            `MIO_REG_IRQ_STAT: rdata_d[2:0] = irq_stat_q;
            `MIO_REG_IRQ_MASK: rdata_d[2:0] = irq_mask_q;
            `MIO_REG_SEG_LO: rdata_d = seg_lat_q[7:0];
            `MIO_REG_SEG_MID: rdata_d = seg_lat_q[15:8];
            `MIO_REG_SEG_HI: rdata_d[6:0] = seg_lat_q[22:16];
            default: rdata_d = {`MIO_DW{1'b0}};
        endcase
        if (!reg_rd)
        begin
            rdata_d = {`MIO_DW{1'b0}};
        end
    end

    // Software registers; data latches reset high except the output port latch, which resets low
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so_lat_q <= `MIO_RST_LATCH; // [R12]
            m_lat_q <= `MIO_RST_LATCH; // [R12]
            p_lat_q <= `MIO_RST_LATCH; // [R12]
            n_lat_q <= `MIO_RST_N_LATCH;
            so_dir_q <= `MIO_RST_DIR; // [R10]
            m_dir_q <= `MIO_RST_DIR; // [R10]
            p_dir_q <= `MIO_RST_DIR; // [R10]
            pull_q <= `MIO_RST_PULL; // [R10]
            od_q <= 3'h0;
            n_od_q <= 4'h0;
            fn_q <= 7'h00;
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            seg_lat_q <= SEG_RST_LIT ? SEG_GPO_MASK : 23'h000000; // [R15]
            boot_done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_stat_q <= irq_stat_d;
            boot_done_q <= 1'b1;
            // Pulls drop once on the first enabled edge after release
            if (!boot_done_q)
            begin
                pull_q <= 3'h0; // [R10]
            end
            if (wr_so)
            begin
                so_lat_q <= reg_wdata[3:0];
            end
            if (wr_m)
            begin
                m_lat_q <= reg_wdata[3:0];
            end
            if (wr_p)
            begin
                p_lat_q <= reg_wdata[3:0];
            end
            if (wr_n)
            begin
                n_lat_q <= reg_wdata[3:0];
            end
            if (reg_wr)
            begin
                case (reg_addr)
                    `MIO_REG_SO_DIR: so_dir_q <= reg_wdata[3:0];
                    `MIO_REG_M_DIR: m_dir_q <= reg_wdata[3:0];
                    `MIO_REG_P_DIR: p_dir_q <= reg_wdata[3:0];
                    `MIO_REG_PORT_CFG:
                    begin
                        pull_q <= reg_wdata[2:0]; // [R04]
                        od_q <= reg_wdata[6:4]; // [R05]
                    end
                    `MIO_REG_N_OD: n_od_q <= reg_wdata[3:0]; // [R06]
                    `MIO_REG_FUNC: fn_q <= reg_wdata[6:0];
                    `MIO_REG_IRQ_MASK: irq_mask_q <= reg_wdata[2:0];
                    `MIO_REG_SEG_LO: seg_lat_q[7:0] <= reg_wdata;
                    `MIO_REG_SEG_MID: seg_lat_q[15:8] <= reg_wdata;
                    `MIO_REG_SEG_HI: seg_lat_q[22:16] <= reg_wdata[6:0];
                    default: so_dir_q <= so_dir_q;
                endcase
            end
        end
    end

    // Pin-facing flops; every output except pull_en comes straight from one of these
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so_pin_q <= 4'h0;
            m_pin_q <= 4'h0;
            p_pin_q <= 4'h0;
            pin_out_q <= 16'h0000;
            pin_oe_n_q <= `MIO_RST_PIN_OE_N; // [R10]
            seg_out_q <= SEG_RST_LIT ? SEG_GPO_MASK : 23'h000000; // [R15]
            keeper_q <= 1'b0; // [R11]
            ser_din_q <= 1'b0;
            ser_cin_q <= 1'b0;
            t2_clk_q <= 1'b0;
            so4_int_q <= 1'b0;
            halt_rel_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= {`MIO_DW{1'b0}};
        end
        else if (clk_en)
        begin
            so_pin_q <= serial_shared_pin_in;
            m_pin_q <= timer_shared_pin_in;
            p_pin_q <= plain_port_pin_in;
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
            seg_out_q <= seg_out_d;
            // Keeper starts right after release when fitted
            keeper_q <= LEVEL_HOLD; // [R11] [R13]
            // Two-wire mode takes data back from the shared data pin
            ser_din_q <= two_wire ? serial_shared_pin_in[1] : serial_shared_pin_in[0]; // [R01] [R02]
            ser_cin_q <= serial_shared_pin_in[2]; // [R01]
            // Gated so the timer sees no stray edges outside counter mode
            t2_clk_q <= t2_evt & timer_shared_pin_in[3]; // [R07]
            so4_int_q <= so4_int_ev; // [R03]
            halt_rel_q <= halt_ev; // [R03]
            irq_q <= |(irq_stat_d & irq_mask_q);
            rdata_q <= rdata_d;
        end
    end

    // Output wiring
    assign serial_shared_pin_out = pin_out_q[3:0];
    assign serial_shared_pin_oe_n = pin_oe_n_q[3:0];
    assign timer_shared_pin_out = pin_out_q[7:4];
    assign timer_shared_pin_oe_n = pin_oe_n_q[7:4];
    assign plain_port_pin_out = pin_out_q[11:8];
    assign plain_port_pin_oe_n = pin_oe_n_q[11:8];
    assign output_port_pin_out = pin_out_q[15:12];
    assign output_port_pin_oe_n = pin_oe_n_q[15:12];
    assign pull_en = pull_q;
    assign keeper_en = keeper_q;
    assign segment_drive_pins = seg_out_q;
    assign ser_data_in = ser_din_q;
    assign ser_clk_in = ser_cin_q;
    assign t2_count_clk = t2_clk_q;
    assign so4_int_req = so4_int_q;
    assign halt_release = halt_rel_q;
    assign irq = irq_q;
    assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* File: hdl/mio_defines.vh */
`ifndef MIO_DEFINES_VH
`define MIO_DEFINES_VH

// Register bus geometry
`define MIO_AW 5
`define MIO_DW 8

// Register offsets
`define MIO_REG_SO_DATA 5'h00
`define MIO_REG_M_DATA 5'h01
`define MIO_REG_P_DATA 5'h02
`define MIO_REG_N_DATA 5'h03
`define MIO_REG_SO_DIR 5'h04
`define MIO_REG_M_DIR 5'h05
`define MIO_REG_P_DIR 5'h06
`define MIO_REG_PORT_CFG 5'h07
`define MIO_REG_N_OD 5'h08
`define MIO_REG_FUNC 5'h09
`define MIO_REG_SO_PIN 5'h0A
`define MIO_REG_M_PIN 5'h0B
`define MIO_REG_P_PIN 5'h0C
`define MIO_REG_IRQ_STAT 5'h0D
`define MIO_REG_IRQ_MASK 5'h0E
`define MIO_REG_SEG_LO 5'h10
`define MIO_REG_SEG_MID 5'h11
`define MIO_REG_SEG_HI 5'h12

// Port configuration fields (pull enables, open-drain selects)
`define MIO_CFG_PULL_SO 0
`define MIO_CFG_PULL_M 1
`define MIO_CFG_PULL_P 2
`define MIO_CFG_OD_SO 4
`define MIO_CFG_OD_M 5
`define MIO_CFG_OD_P 6

// Function control fields
`define MIO_FN_SER_EN 0
`define MIO_FN_TWO_WIRE 1
`define MIO_FN_SO4_EN 2
`define MIO_FN_SO4_INT 3
`define MIO_FN_T2_EVT 4
`define MIO_FN_CARRIER 5
`define MIO_FN_ALARM 6

// Interrupt status fields
`define MIO_IRQ_SO4_INT 0
`define MIO_IRQ_HALT_REL 1
`define MIO_IRQ_T2_EDGE 2

// Reset values
`define MIO_RST_LATCH 4'hF
`define MIO_RST_DIR 4'h0
`define MIO_RST_N_LATCH 4'h0
`define MIO_RST_PULL 3'h7
`define MIO_RST_CFG 8'h07
`define MIO_RST_PIN_OE_N 16'h0FFF

`endif

/* File: dv/mio_board.sv */
`timescale 1ns/1ps
`default_nettype none
module mio_board (
    // Clock
    input wire sys_clk,
    // Pads of the three two-way ports, serial bits 3:0, timer 7:4, plain 11:8
    input wire [11:0] pad_out,
    input wire [11:0] pad_oe_n,
    input wire [2:0] pull_en,
    input wire keeper_en,
    // Outside drivers commanded by the bench
    input wire [11:0] ext_en,
    input wire [11:0] ext_val,
    output logic [11:0] pad_in
);
    logic [11:0] last_q = 12'h000;
    integer b;
    // Wire level: chip driver wins, then outside driver, pull-up, keeper
    always @*
    begin
        for (b = 0; b < 12; b = b + 1)
        begin
            if (!pad_oe_n[b])
                pad_in[b] = pad_out[b];
            else if (ext_en[b])
                pad_in[b] = ext_val[b];
            else if (pull_en[b / 4])
                pad_in[b] = 1'b1;
            else if (keeper_en)
                pad_in[b] = last_q[b];
            else
                pad_in[b] = ~last_q[b]; // Floating pin never looks steady
        end
    end
    // Last level seen, for keeper and float
    always @(posedge sys_clk)
        last_q <= pad_in;
endmodule
`default_nettype wire

/* File: dv/mio_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mio_checker #(
    parameter [22:0] SEG_GPO_MASK = 23'h000000,
    parameter LEVEL_HOLD = 1'b1
) (
    // Clock, reset, register writes
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    // Pins and alternate functions
    input wire [3:0] serial_shared_pin_in,
    input wire [3:0] serial_shared_pin_out,
    input wire [3:0] serial_shared_pin_oe_n,
    input wire [3:0] timer_shared_pin_in,
    input wire [3:0] timer_shared_pin_oe_n,
    input wire [3:0] output_port_pin_out,
    input wire [2:0] pull_en,
    input wire keeper_en,
    input wire [22:0] seg_lcd_drive,
    input wire [22:0] segment_drive_pins,
    input wire ser_data_out,
    input wire ser_data_in,
    input wire t2_count_clk,
    input wire carrier_wave,
    input wire alarm_wave,
    input wire so4_int_req,
    input wire halt_release
);
    reg [7:0] fn_q;
    reg [7:0] cfg_q;
    reg [7:0] nod_q;
    // Shadow of the function register, so pin ownership is known here
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            fn_q <= 8'h00;
        else if (clk_en && reg_wr && reg_addr == 5'h09)
            fn_q <= reg_wdata;
    end
    // Shadows of drive types; an open-drain pin shows 0 on its data output
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q <= 8'h00;
            nod_q <= 8'h00;
        end
        else if (clk_en && reg_wr && reg_addr == 5'h07)
            cfg_q <= reg_wdata;
        else if (clk_en && reg_wr && reg_addr == 5'h08)
            nod_q <= reg_wdata;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_pull_boot: assert property (!$past(rst_n) |=> pull_en == 3'h0)
        else $error("pulls not cleared after reset");
    chk_keeper_boot: assert property (!$past(rst_n) |=> keeper_en == LEVEL_HOLD)
        else $error("keeper not started after reset");
    chk_event_clock: assert property (fn_q[4] |=>
        t2_count_clk == $past(timer_shared_pin_in[3]) && timer_shared_pin_oe_n[3])
        else $error("timer pin not routed as count clock");
    chk_carrier_out: assert property (fn_q[5] && !nod_q[2] |=>
        output_port_pin_out[2] == $past(carrier_wave))
        else $error("carrier not on output pin 3");
    chk_alarm_out: assert property (fn_q[6] && !nod_q[3] |=>
        output_port_pin_out[3] == $past(alarm_wave))
        else $error("alarm not on output pin 4");
    chk_serial_pins: assert property (fn_q[1:0] == 2'b01 && !cfg_q[4] |=> ser_data_in ==
        $past(serial_shared_pin_in[0]) && serial_shared_pin_out[1] == $past(ser_data_out))
        else $error("serial pins not routed");
    chk_two_wire: assert property (fn_q[1:0] == 2'b11 |=> ser_data_in ==
        $past(serial_shared_pin_in[1]) && serial_shared_pin_oe_n[1] == $past(ser_data_out))
        else $error("two-wire data pin wrong");
    chk_pin4_event: assert property (!fn_q[0] && fn_q[2] && $fell(serial_shared_pin_in[3]) |=>
        so4_int_req == $past(fn_q[3]) && halt_release != $past(fn_q[3]))
        else $error("pin 4 event pulse wrong");
    chk_pin4_quiet: assert property (fn_q[0] |=> !so4_int_req && !halt_release)
        else $error("pin 4 event while serial on");
    chk_seg_lcd: assert property (rst_n |=> (segment_drive_pins & ~SEG_GPO_MASK) ==
        ($past(seg_lcd_drive) & ~SEG_GPO_MASK))
        else $error("display segment not passed through");
endmodule
bind mio_ports mio_checker #(
    .SEG_GPO_MASK(SEG_GPO_MASK),
    .LEVEL_HOLD(LEVEL_HOLD)
) mio_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .serial_shared_pin_in(serial_shared_pin_in),
    .serial_shared_pin_out(serial_shared_pin_out),
    .serial_shared_pin_oe_n(serial_shared_pin_oe_n), .timer_shared_pin_in(timer_shared_pin_in),
    .timer_shared_pin_oe_n(timer_shared_pin_oe_n), .output_port_pin_out(output_port_pin_out),
    .pull_en(pull_en), .keeper_en(keeper_en), .seg_lcd_drive(seg_lcd_drive),
    .segment_drive_pins(segment_drive_pins), .ser_data_out(ser_data_out),
    .ser_data_in(ser_data_in), .t2_count_clk(t2_count_clk), .carrier_wave(carrier_wave),
    .alarm_wave(alarm_wave), .so4_int_req(so4_int_req), .halt_release(halt_release)
);
`default_nettype wire

/* File: dv/mio_ports_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mio_defines.vh"
module mio_ports_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ser_data_out = 1'b0;
    logic carrier_wave = 1'b0;
    logic alarm_wave = 1'b0;
    logic [22:0] seg_lcd = 23'h5A5A50;
    logic [11:0] ext_en = 12'h000;
    logic [11:0] ext_val = 12'h000;
    wire [7:0] reg_rdata;
    wire [3:0] so_out, so_oe, tm_out, tm_oe, pl_out, pl_oe, op_out, op_oe;
    wire [11:0] pad_in;
    wire [2:0] pull_en;
    wire [22:0] seg_pins;
    wire keeper_en, ser_data_in, ser_clk_in, t2_count_clk, so4_int_req, halt_release, irq;
    integer n_errors = 0;
    integer checked = 0;
    integer cyc = 0;
    // Clock; clk_en and the serial clock inputs stay tied off
    always #5 sys_clk = ~sys_clk;
    mio_ports #(
        .SEG_GPO_MASK(23'h00000F),
        .SEG_RST_LIT(1'b1)
    ) mio_ports_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_shared_pin_in(pad_in[3:0]), .serial_shared_pin_out(so_out),
        .serial_shared_pin_oe_n(so_oe), .timer_shared_pin_in(pad_in[7:4]),
        .timer_shared_pin_out(tm_out), .timer_shared_pin_oe_n(tm_oe),
        .plain_port_pin_in(pad_in[11:8]), .plain_port_pin_out(pl_out),
        .plain_port_pin_oe_n(pl_oe), .output_port_pin_out(op_out), .output_port_pin_oe_n(op_oe),
        .pull_en(pull_en), .keeper_en(keeper_en), .seg_lcd_drive(seg_lcd),
        .segment_drive_pins(seg_pins), .ser_data_out(ser_data_out), .ser_clk_out(1'b0),
        .ser_clk_drive(1'b0), .ser_data_in(ser_data_in), .ser_clk_in(ser_clk_in),
        .t2_count_clk(t2_count_clk), .carrier_wave(carrier_wave), .alarm_wave(alarm_wave),
        .so4_int_req(so4_int_req), .halt_release(halt_release), .irq(irq)
    );
    mio_board mio_board_i (
        .sys_clk(sys_clk), .pad_out({pl_out, tm_out, so_out}), .pad_oe_n({pl_oe, tm_oe, so_oe}),
        .pull_en(pull_en), .keeper_en(keeper_en), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in)
    );
    task chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge sys_clk);
        #1;
    end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
    begin
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input string what, input logic [4:0] a, input logic [7:0] exp);
    begin
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    end
    endtask
    // Pin 4 high, then falling, then look at the pulse cycle
    task pin4_fall;
    begin
        @(posedge sys_clk);
        ext_en <= 12'h008;
        ext_val <= 12'h008;
        tick(2);
        ext_val <= 12'h000;
        tick(1);
    end
    endtask
    task give_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end
    initial
    begin
        tick(1);
        chk("pull in reset", 23'h7, pull_en);
        chk("keeper in reset", 23'h0, keeper_en);
        chk("serial oe_n in reset", 23'hF, so_oe);
        chk("segments in reset", 23'h00000F, seg_pins);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(2);
        chk("pull after reset", 23'h0, pull_en);
        chk("keeper after reset", 23'h1, keeper_en);
        rd("serial latch", `MIO_REG_SO_DATA, 8'h0F);
        rd("timer latch", `MIO_REG_M_DATA, 8'h0F);
        rd("plain latch", `MIO_REG_P_DATA, 8'h0F);
        rd("unmapped", 5'h1F, 8'h00);
        $display("Test reset done");
        wr(`MIO_REG_PORT_CFG, 8'h45);
        wr(`MIO_REG_P_DIR, 8'h0F);
        wr(`MIO_REG_P_DATA, 8'h0A);
        tick(1);
        chk("pull select", 23'h5, pull_en);
        chk("plain od out", 23'h0, pl_out);
        chk("plain od oe_n", 23'hA, pl_oe);
        wr(`MIO_REG_PORT_CFG, 8'h00);
        tick(1);
        chk("plain cmos out", 23'hA, pl_out);
        chk("plain cmos oe_n", 23'h0, pl_oe);
        wr(`MIO_REG_N_OD, 8'h03);
        wr(`MIO_REG_N_DATA, 8'h05);
        tick(1);
        chk("output port out", 23'h4, op_out);
        chk("output port oe_n", 23'h1, op_oe);
        $display("Test drive types done");
        alarm_wave <= 1'b1;
        wr(`MIO_REG_FUNC, 8'h60);
        tick(1);
        chk("alarm only", 23'h8, op_out);
        carrier_wave <= 1'b1;
        tick(2);
        chk("carrier and alarm", 23'hC, op_out);
        wr(`MIO_REG_FUNC, 8'h00);
        tick(1);
        chk("latch restored", 23'h4, op_out);
        wr(`MIO_REG_M_DIR, 8'h0F);
        wr(`MIO_REG_FUNC, 8'h10);
        ext_en <= 12'h080;
        ext_val <= 12'h000;
        tick(2);
        chk("count clock low", 23'h0, t2_count_clk);
        chk("timer pin released", 23'h1, tm_oe[3]);
        ext_val <= 12'h080;
        tick(2);
        chk("count clock high", 23'h1, t2_count_clk);
        chk("masked irq", 23'h0, irq);
        rd("timer edge status", `MIO_REG_IRQ_STAT, 8'h04);
        $display("Test alternate outputs done");
        wr(`MIO_REG_FUNC, 8'h01);
        ser_data_out <= 1'b0;
        ext_en <= 12'h005;
        ext_val <= 12'h005;
        tick(2);
        chk("serial data in", 23'h1, ser_data_in);
        chk("serial clock in", 23'h1, ser_clk_in);
        chk("serial out pin", 23'h0, {so_oe[1], so_out[1]});
        wr(`MIO_REG_FUNC, 8'h03);
        ser_data_out <= 1'b1;
        ext_en <= 12'h002;
        ext_val <= 12'h000;
        tick(2);
        chk("two-wire release", 23'h1, so_oe[1]);
        chk("two-wire data in", 23'h0, ser_data_in);
        $display("Test serial done");
        wr(`MIO_REG_FUNC, 8'h0C);
        wr(`MIO_REG_IRQ_MASK, 8'h01);
        pin4_fall;
        chk("int request pulse", 23'h1, so4_int_req);
        tick(1);
        chk("irq raised", 23'h1, irq);
        rd("int status", `MIO_REG_IRQ_STAT, 8'h01);
        tick(1);
        chk("irq cleared", 23'h0, irq);
        wr(`MIO_REG_FUNC, 8'h04);
        pin4_fall;
        chk("halt release pulse", 23'h1, halt_release);
        tick(1);
        chk("halt masked", 23'h0, irq);
        rd("halt status", `MIO_REG_IRQ_STAT, 8'h02);
        wr(`MIO_REG_SEG_LO, 8'h0A);
        tick(1);
        chk("segment mix", 23'h5A5A5A, seg_pins);
        $display("Test events and segments done");
        give_verdict;
    end
endmodule
`default_nettype wire
